// file: lsm_pkg.sv
// constants and types for the line-state match and maintenance source block
`default_nettype none
package lsm_pkg;
    // control word field positions
    localparam int MATCH_SEL_HI = 14;
    localparam int MATCH_SEL_LO = 11;
    localparam int MAINTENANCE_TX_LINE_STATE_HI = 10;
    localparam int MAINTENANCE_TX_LINE_STATE_LO = 8;
    localparam logic [15:0] CNTRL_RESET = 16'h0000;

    // match selection bit positions within the four-bit field
    localparam int SEL_QUIET = 3;
    localparam int SEL_MASTER = 2;
    localparam int SEL_HALT = 1;
    localparam int SEL_IDLE = 0;
    localparam logic [3:0] SEL_NONE = 4'h0;

    // current line-state encoding
    typedef enum logic [2:0] {
        LS_QUIET = 3'h0,
        LS_IDLE = 3'h1,
        LS_HALT = 3'h2,
        LS_MASTER = 3'h3,
        LS_ACTIVE = 3'h4,
        LS_NOISE = 3'h5
    } line_state_t;

    // maintenance transmit line-state selector
    localparam logic [2:0] MLS_QUIET = 3'h0;
    localparam logic [2:0] MLS_IDLE = 3'h1;
    localparam logic [2:0] MLS_HALT = 3'h2;
    localparam logic [2:0] MLS_MASTER = 3'h3;
    localparam logic [2:0] MLS_PASS = 3'h6;

    // idle qualification: sixteen symbols equal eight symbol-pair bytes
    localparam int IDLE_SYMBOLS = 16;
    localparam int IDLE_BYTES = IDLE_SYMBOLS / 2;
    localparam logic [3:0] IDLE_COUNT_MAX = 4'(IDLE_BYTES);

    // symbol-pair codes (5-bit symbols, two per byte)
    localparam logic [9:0] PAIR_QUIET = 10'h000;
    localparam logic [9:0] PAIR_IDLE = 10'h3ff;
    localparam logic [9:0] PAIR_HALT = 10'h084;
    localparam logic [9:0] PAIR_MASTER = 10'h087;

    typedef enum logic [1:0] {
        CM_OFF = 2'b01,
        CM_MAINTENANCE_STATE = 2'b10
    } cm_state_t;
endpackage : lsm_pkg
`default_nettype wire

// file: idle_qualifier.sv
// counts consecutive idle bytes and flags idle after sixteen symbols
`default_nettype none
module idle_qualifier (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic idle_byte_in,
    output logic idle_qualified_out
);
    import lsm_pkg::*;

    logic [3:0] count_r;
    logic [3:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (!idle_byte_in) begin
            count_nxt = 4'h0;
        end else if (count_r != IDLE_COUNT_MAX) begin
            count_nxt = count_r + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_r <= 4'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // fewer than eight idle bytes never count as idle
    assign idle_qualified_out = idle_byte_in && (count_r == IDLE_COUNT_MAX);
endmodule : idle_qualifier
`default_nettype wire

// file: line_state_match_and_maintenance_state_source.sv
// line-state match event and maintenance transmit line-state source
`default_nettype none
// Function
// - Select bit 3 set: match event when line state becomes Quiet.
// - Select bit 2 set: match event when line state becomes Master.
// - Select bit 1 set: match event when line state becomes Halt.
// - Select bit 0 set: match event when line state becomes qualified Idle.
// - Idle counts only after sixteen idle symbols, eight idle bytes.
// - Maintenance line-state field sits at control bits 10 to 8.
// - Enter maintenance from OFF only when maintenance request asserted in OFF.
// - Maintenance with field 000 transmits Quiet.
// - Maintenance with field 001 transmits Idle continuously.
// - Maintenance with field 010 transmits Halt continuously.
// - Maintenance with field 011 transmits Master continuously.
// - Select field at bits 14 to 11; matches OR into event bit.
// - Select all zero: event on any line-state or unknown-flag change.
// - Values 100, 101, 111 give Quiet; 110 passes host data through.
// - Whole control word cleared by device reset.
module line_state_match_and_maintenance_state_source (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic CNTRL_WR_IN,
    input wire logic [15:0] CNTRL_WDATA_IN,
    output logic [15:0] CNTRL_RDATA_OUT,
    input wire lsm_pkg::line_state_t CURRENT_LINE_STATE_IN,
    input wire logic UNKNOWN_LINE_STATE_FLAG_IN,
    input wire logic IDLE_BYTE_IN,
    input wire logic MAINTENANCE_ENTRY_REQUEST_IN,
    input wire logic MAINTENANCE_STATE_EXIT_IN,
    input wire logic EVENT_CLEAR_IN,
    output logic LINE_STATE_MATCH_EVENT_OUT,
    output logic IDLE_AFTER_SIXTEEN_SYMBOLS_OUT,
    output logic MAINTENANCE_STATE_OUT,
    input wire logic [9:0] TX_DATA_IN,
    output logic [9:0] TX_PAIR_OUT
);
    import lsm_pkg::*;

    // registers and their next values
    logic [15:0] cntrl_r;
    logic [15:0] cntrl_nxt;
    cm_state_t cm_r;
    cm_state_t cm_nxt;
    logic maintenance_state_flag_r;
    logic maintenance_state_flag_nxt;
    line_state_t ls_prev_r;
    line_state_t ls_prev_nxt;
    logic unk_prev_r;
    logic unk_prev_nxt;
    logic match_prev_r;
    logic match_prev_nxt;
    logic event_r;
    logic event_nxt;
    logic [9:0] tx_r;
    logic [9:0] tx_nxt;

    // decoded fields and match terms
    logic idle_q;
    logic [3:0] match_sel;
    logic [2:0] maintenance_tx_line_state;
    logic quiet_hit;
    logic master_hit;
    logic halt_hit;
    logic idle_hit;
    logic match_now;
    logic ls_change;
    logic unk_change;
    logic change_now;
    logic entry_now;
    logic hit;

    // the qualifier watches every byte, whatever the select
    idle_qualifier u_idle (
        .clk_in(CLK_SYS_IN),
        .reset_n_in(RESET_N_IN),
        .idle_byte_in(IDLE_BYTE_IN),
        .idle_qualified_out(idle_q)
    );

    // field views of the control word
    assign match_sel = cntrl_r[MATCH_SEL_HI:MATCH_SEL_LO];
    assign maintenance_tx_line_state = cntrl_r[MAINTENANCE_TX_LINE_STATE_HI:MAINTENANCE_TX_LINE_STATE_LO];

    // control word: every bit is stored and read back
    always_comb begin
        cntrl_nxt = cntrl_r;
        if (CNTRL_WR_IN) begin
            cntrl_nxt = CNTRL_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESET_N_IN) begin
            cntrl_r <= CNTRL_RESET;
        end else begin
            cntrl_r <= cntrl_nxt;
        end
    end

    // connection manager: off and maintenance only
    always_comb begin
        cm_nxt = cm_r;
        unique case (cm_r)
            CM_OFF: begin
                if (MAINTENANCE_ENTRY_REQUEST_IN) begin
                    cm_nxt = CM_MAINTENANCE_STATE;
                end
            end
            CM_MAINTENANCE_STATE: begin
                if (MAINTENANCE_STATE_EXIT_IN) begin
                    cm_nxt = CM_OFF;
                end
            end
            default: cm_nxt = CM_OFF;
        endcase
        maintenance_state_flag_nxt = (cm_nxt == CM_MAINTENANCE_STATE);
    end

    // the manager leaves reset in off, transmitting quiet
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESET_N_IN) begin
            cm_r <= CM_OFF;
            maintenance_state_flag_r <= 1'b0;
        end else begin
            cm_r <= cm_nxt;
            maintenance_state_flag_r <= maintenance_state_flag_nxt;
        end
    end

    // one term per selectable line state; the terms are ORed
    assign quiet_hit = match_sel[SEL_QUIET] && (CURRENT_LINE_STATE_IN == LS_QUIET);
    assign master_hit = match_sel[SEL_MASTER] && (CURRENT_LINE_STATE_IN == LS_MASTER);
    assign halt_hit = match_sel[SEL_HALT] && (CURRENT_LINE_STATE_IN == LS_HALT);

    // idle only counts once eight idle bytes have been seen
    assign idle_hit = match_sel[SEL_IDLE] && (CURRENT_LINE_STATE_IN == LS_IDLE)
        && idle_q;
    assign match_now = quiet_hit || master_hit || halt_hit || idle_hit;

    // compare against the previous cycle, unknown flag included
    assign ls_change = (CURRENT_LINE_STATE_IN != ls_prev_r);
    assign unk_change = (UNKNOWN_LINE_STATE_FLAG_IN != unk_prev_r);
    assign change_now = ls_change || unk_change;

    // a newly enabled select and a move between selected states both count as entry
    assign entry_now = match_now && (!match_prev_r || ls_change);
    assign hit = (match_sel == SEL_NONE) ? change_now : entry_now;

    // previous-cycle history for change and entry detection
    always_comb begin
        ls_prev_nxt = CURRENT_LINE_STATE_IN;
        unk_prev_nxt = UNKNOWN_LINE_STATE_FLAG_IN;
        match_prev_nxt = match_now;
    end

    // history starts at quiet, the line state expected out of reset
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESET_N_IN) begin
            ls_prev_r <= LS_QUIET;
            unk_prev_r <= 1'b0;
            match_prev_r <= 1'b0;
        end else begin
            ls_prev_r <= ls_prev_nxt;
            unk_prev_r <= unk_prev_nxt;
            match_prev_r <= match_prev_nxt;
        end
    end

    // sticky event: a hit in the clearing cycle is kept, so no match is lost
    always_comb begin
        event_nxt = event_r;
        if (EVENT_CLEAR_IN) begin
            event_nxt = 1'b0;
        end
        if (hit) begin
            event_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESET_N_IN) begin
            event_r <= 1'b0;
        end else begin
            event_r <= event_nxt;
        end
    end

    // maintenance transmit source
    always_comb begin
        tx_nxt = PAIR_QUIET;
        if (cm_r == CM_MAINTENANCE_STATE) begin
            unique case (maintenance_tx_line_state)
                MLS_QUIET: tx_nxt = PAIR_QUIET;
                MLS_IDLE: tx_nxt = PAIR_IDLE;
                MLS_HALT: tx_nxt = PAIR_HALT;
                MLS_MASTER: tx_nxt = PAIR_MASTER;
                MLS_PASS: tx_nxt = TX_DATA_IN;
                default: tx_nxt = PAIR_QUIET;
            endcase
        end
    end

    // registered so the line never sees a decode glitch
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESET_N_IN) begin
            tx_r <= PAIR_QUIET;
        end else begin
            tx_r <= tx_nxt;
        end
    end

    // every output but the idle flag comes from a register
    assign CNTRL_RDATA_OUT = cntrl_r;
    assign LINE_STATE_MATCH_EVENT_OUT = event_r;
    assign IDLE_AFTER_SIXTEEN_SYMBOLS_OUT = idle_q;
    assign MAINTENANCE_STATE_OUT = maintenance_state_flag_r;
    assign TX_PAIR_OUT = tx_r;
endmodule : line_state_match_and_maintenance_state_source
`default_nettype wire

// file: lsm_properties.sv
// port assertions for the line-state match and maintenance source
`default_nettype none
module lsm_properties (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic CNTRL_WR_IN,
    input wire logic [15:0] CNTRL_WDATA_IN,
    input wire logic [15:0] CNTRL_RDATA_OUT,
    input wire lsm_pkg::line_state_t CURRENT_LINE_STATE_IN,
    input wire logic MAINTENANCE_ENTRY_REQUEST_IN,
    input wire logic EVENT_CLEAR_IN,
    input wire logic LINE_STATE_MATCH_EVENT_OUT,
    input wire logic IDLE_AFTER_SIXTEEN_SYMBOLS_OUT,
    input wire logic MAINTENANCE_STATE_OUT,
    input wire logic [9:0] TX_PAIR_OUT
);
    import lsm_pkg::*;
    logic [3:0] sel;
    logic ev, mt;
    line_state_t ls;
    assign sel = CNTRL_RDATA_OUT[14:11];
    assign ev = LINE_STATE_MATCH_EVENT_OUT;
    assign mt = MAINTENANCE_STATE_OUT;
    assign ls = CURRENT_LINE_STATE_IN;
    default clocking @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    AST_QUIET_HIT: assert property (
        sel == 4'h8 && $stable(sel) && ls == LS_QUIET && $past(ls) != LS_QUIET |=> ev)
        else $error("quiet match missed");
    AST_IDLE_HIT: assert property (
        sel == 4'h1 && $stable(sel) && ls == LS_IDLE
        && $rose(IDLE_AFTER_SIXTEEN_SYMBOLS_OUT) |=> ev)
        else $error("idle match missed");
    AST_HALT_HIT: assert property (
        sel[1] && $stable(sel) && ls == LS_HALT && $past(ls) != LS_HALT |=> ev)
        else $error("halt entry missed");
    AST_ANY_CHANGE: assert property (
        sel == 4'h0 && $stable(sel) && ls != $past(ls) |=> ev) else $error("change missed");
    AST_EVENT_HOLDS: assert property (
        ev && !EVENT_CLEAR_IN |=> ev) else $error("event dropped");
    AST_EVENT_CLEARS: assert property (
        EVENT_CLEAR_IN && sel == 4'h8 && ls != LS_QUIET |=> !ev) else $error("no clear");
    AST_MAINTENANCE_STATE_ENTRY: assert property (
        !mt |=> mt == $past(MAINTENANCE_ENTRY_REQUEST_IN)) else $error("bad maintenance_state entry");
    AST_OFF_QUIET: assert property (
        !mt |=> TX_PAIR_OUT == PAIR_QUIET) else $error("off not quiet");
    AST_READBACK: assert property (
        CNTRL_WR_IN |=> CNTRL_RDATA_OUT == $past(CNTRL_WDATA_IN)) else $error("bad readback");
endmodule : lsm_properties
bind line_state_match_and_maintenance_state_source lsm_properties u_props (.CLK_SYS_IN, .RESET_N_IN,
    .CNTRL_WR_IN, .CNTRL_WDATA_IN, .CNTRL_RDATA_OUT, .CURRENT_LINE_STATE_IN,
    .MAINTENANCE_ENTRY_REQUEST_IN, .EVENT_CLEAR_IN, .LINE_STATE_MATCH_EVENT_OUT,
    .IDLE_AFTER_SIXTEEN_SYMBOLS_OUT, .MAINTENANCE_STATE_OUT, .TX_PAIR_OUT);
`default_nettype wire

// file: line_state_match_and_maintenance_state_source_test.sv
// self-checking bench for the line-state match and maintenance source
`default_nettype none
module line_state_match_and_maintenance_state_source_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lsm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, unk = 1'b0, idle_b = 1'b0;
    logic mreq = 1'b0, mexit = 1'b0, eclr = 1'b0, ev, idle_q, maintenance_state;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [9:0] txd = 10'h000, txp;
    line_state_t ls = LS_QUIET;
    line_state_t tgt [3] = '{LS_QUIET, LS_MASTER, LS_HALT};
    int n_fail = 0, samples_checked = 0, seed = 14;
    line_state_match_and_maintenance_state_source dut (.CLK_SYS_IN(clk), .RESET_N_IN(reset_n),
        .CNTRL_WR_IN(wr), .CNTRL_WDATA_IN(wdata), .CNTRL_RDATA_OUT(rdata),
        .CURRENT_LINE_STATE_IN(ls), .UNKNOWN_LINE_STATE_FLAG_IN(unk), .IDLE_BYTE_IN(idle_b),
        .MAINTENANCE_ENTRY_REQUEST_IN(mreq), .MAINTENANCE_STATE_EXIT_IN(mexit), .EVENT_CLEAR_IN(eclr),
        .LINE_STATE_MATCH_EVENT_OUT(ev), .IDLE_AFTER_SIXTEEN_SYMBOLS_OUT(idle_q),
        .MAINTENANCE_STATE_OUT(maintenance_state), .TX_DATA_IN(txd), .TX_PAIR_OUT(txp));
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_cntrl(input logic [15:0] w);
        wr = 1'b1;
        wdata = w;
        step(1);
        wr = 1'b0;
    endtask : wr_cntrl
    task automatic clr();
        eclr = 1'b1;
        step(1);
        eclr = 1'b0;
        step(1);
    endtask : clr
    function automatic logic [9:0] exp_pair(input logic [2:0] f, input logic [9:0] d);
        case (f)
            MLS_IDLE: return PAIR_IDLE;
            MLS_HALT: return PAIR_HALT;
            MLS_MASTER: return PAIR_MASTER;
            MLS_PASS: return d;
            default: return PAIR_QUIET;
        endcase
    endfunction : exp_pair
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        step(10);
        reset_n = 1'b1;
        check("reset word", 16'h0000, rdata);
        check("reset pair", 16'h0000, {6'h00, txp});
        wdata = 16'($random(seed));
        wr_cntrl(wdata);
        check("readback", wdata, rdata);
        $display("control test done");
        for (int i = 0; i < 3; i++) begin
            ls = LS_ACTIVE;
            wr_cntrl(16'h4000 >> i);
            clr();
            ls = tgt[(i + 1) % 3];
            step(1);
            check("unselected", 16'h0000, 16'(ev));
            ls = tgt[i];
            step(1);
            check("selected", 16'h0001, 16'(ev));
            clr();
            check("persist", 16'h0000, 16'(ev));
        end
        ls = LS_ACTIVE;
        wr_cntrl(16'h0800);
        clr();
        ls = LS_IDLE;
        idle_b = 1'b1;
        step(8);
        check("idle early", 16'h0000, 16'(ev));
        check("idle qual", 16'h0001, 16'(idle_q));
        step(1);
        check("idle match", 16'h0001, 16'(ev));
        idle_b = 1'b0;
        wr_cntrl(16'h0000);
        clr();
        unk = 1'b1;
        step(1);
        check("flag change", 16'h0001, 16'(ev));
        step(3);
        check("sticky", 16'h0001, 16'(ev));
        clr();
        ls = LS_HALT;
        step(1);
        check("line change", 16'h0001, 16'(ev));
        ls = LS_ACTIVE;
        wr_cntrl(16'h3000);
        clr();
        ls = LS_MASTER;
        step(1);
        check("or master", 16'h0001, 16'(ev));
        clr();
        ls = LS_HALT;
        step(1);
        check("or halt", 16'h0001, 16'(ev));
        $display("match test done");
        step(3);
        check("off", 16'h0000, 16'(maintenance_state));
        mreq = 1'b1;
        step(1);
        mreq = 1'b0;
        check("maintenance_state", 16'h0001, 16'(maintenance_state));
        for (int f = 0; f < 8; f++) begin
            txd = 10'($random(seed));
            wr_cntrl(16'(f) << 8);
            step(1);
            check("tx pair", 16'(exp_pair(3'(f), txd)), 16'(txp));
        end
        wr_cntrl(16'h0100);
        mexit = 1'b1;
        step(1);
        check("idle pair", 16'(PAIR_IDLE), 16'(txp));
        mexit = 1'b0;
        step(1);
        check("exit pair", 16'(PAIR_QUIET), 16'(txp));
        $display("maintenance test done");
        conclude();
    end
endmodule : line_state_match_and_maintenance_state_source_test
`default_nettype wire
